// >>> common/prb_pkg.sv
// ============================================================
// Phrase ROM control: shared constants and carrier types
package prb_pkg;

    // ============================================================
    // Clock and ROM geometry
    localparam int CLK_PERIOD_NS = 10;
    localparam int ROM_AW = 21;
    localparam int CNT_W = 24;
    localparam logic [20:0] CTRL_BASE = 21'h000000;
    localparam logic [20:0] TEST_BASE = 21'h002000;
    localparam logic [20:0] TEST_END = 21'h00205F;
    localparam logic [20:0] WAVE_BASE = 21'h002060;
    localparam logic [20:0] HALF_BASE = 21'h100000;
    localparam int QUARTER_SHIFT = 19;

    // ============================================================
    // Control table entry layout (stride 8 bytes, 7 used)
    localparam logic [2:0] ENTRY_LAST = 3'h6;
    localparam logic [2:0] ENTRY_FLAGS = 3'h0;
    localparam logic [2:0] ENTRY_START_LAST = 3'h3;
    localparam int FLAG_EDIT_BIT = 7;

    // ============================================================
    // Command bytes and fields
    localparam logic [7:0] CMD_PUP_MASK = 8'hFC;
    localparam logic [7:0] CMD_PUP_VAL = 8'h00;
    localparam logic [7:0] CMD_POWER_DOWN_COMMAND = 8'h20;
    localparam logic [7:0] CMD_ANALOG_MODE_COMMAND = 8'h04;
    localparam logic [7:0] CMD_PLAY_MASK = 8'hF3;
    localparam logic [7:0] CMD_PLAY_VAL = 8'h40;
    localparam int PLAY_HI_LSB = 2;
    localparam int ANALOG_MODE_COMMAND_SPEN_BIT = 1;
    localparam logic [1:0] BANKS_ONE = 2'h0;
    localparam logic [1:0] BANKS_TWO = 2'h1;
    localparam logic [1:0] BANK_CNT_RST = 2'h0;

    // ============================================================
    // Edit sequence items (two bytes each)
    localparam logic [1:0] ITEM_PHRASE = 2'h1;
    localparam logic [1:0] ITEM_SILENCE = 2'h2;

    // ============================================================
    // Timing
    localparam int SIL_MIN_MS = 20;
    localparam int SIL_MAX_MS = 1024;
    localparam int SIL_STEP_MS = 4;
    localparam logic [8:0] SIL_BASE_TICKS = 9'(SIL_MIN_MS / SIL_STEP_MS);
    localparam logic [7:0] SIL_MAX_STEPS =
        8'((SIL_MAX_MS - SIL_MIN_MS) / SIL_STEP_MS);
    localparam int SIL_STEP_CYC_DEF = SIL_STEP_MS * 1000000 / CLK_PERIOD_NS;
    localparam int OSC_STAB_US = 500;
    localparam int OSC_STAB_CYC_DEF = OSC_STAB_US * 1000 / CLK_PERIOD_NS;
    localparam int CMD_PROC_NS = 40;
    localparam int CMD_PROC_CYC =
        (CMD_PROC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ============================================================
    // Enumerations
    typedef enum logic [3:0] {
        S_PDOWN, S_OSC, S_IDLE, S_CMD, S_POWER_DOWN_COMMAND, S_FREQ, S_FWAIT,
        S_PLAY, S_SREQ, S_SWAIT, S_SIL
    } prb_state_t;

    typedef enum logic [1:0] {
        FMT_ADPCM4, FMT_NLPCM8, FMT_PCM8, FMT_PCM16
    } prb_fmt_t;

    // ============================================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } prb_cmd_t;

    typedef struct packed {
        logic rd;
        logic [20:0] addr;
    } prb_rom_req_t;

    typedef struct packed {
        logic start;
        prb_fmt_t format;
        logic [20:0] start_addr;
        logic [20:0] stop_addr;
    } prb_play_t;

endpackage

// >>> rtl/prb_bank_map.sv
`timescale 1ns/1ps
// ============================================================
// Bank base address from bank count and select pins
module prb_bank_map
    import prb_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Configuration and pins
    input wire logic [1:0] bank_cnt_i,
    input wire logic bank_pick_lo_pin_i,
    input wire logic bank_pick_hi_pin_i,
    // Result
    output logic [20:0] base_o
);

    typedef struct packed {
        logic [20:0] base;
    } prb_map_st_t;

    prb_map_st_t r, nx;

    // Pins that the bank count does not use are never looked at
    always_comb begin
        nx = r;
        if (bank_cnt_i == BANKS_ONE) begin
            nx.base = CTRL_BASE;
        end else if (bank_cnt_i == BANKS_TWO) begin
            nx.base = bank_pick_lo_pin_i ? HALF_BASE : CTRL_BASE;
        end else begin
            // Code 11 takes the four-bank path as well
            nx.base = 21'({bank_pick_hi_pin_i, bank_pick_lo_pin_i})
                      << QUARTER_SHIFT;
        end
    end

    // State register
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r <= '0;
        end else begin
            r <= nx;
        end
    end

    assign base_o = r.base;

    // ============================================================
    // Checks
    a_bank_single: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        bank_cnt_i == BANKS_ONE |=> base_o == CTRL_BASE)
        else $error("single bank base not zero");
    a_bank_four: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        bank_cnt_i[1] |=> base_o == {$past(bank_pick_hi_pin_i),
        $past(bank_pick_lo_pin_i), 19'h0})
        else $error("four bank base wrong");
    a_bank_two: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        bank_cnt_i == BANKS_TWO |=>
        base_o == ($past(bank_pick_lo_pin_i) ? HALF_BASE : CTRL_BASE))
        else $error("two bank base wrong");

endmodule // prb_bank_map

// >>> rtl/prb_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Format from stored flags: 4-bit adaptive, nonlinear 8, PCM8, PCM16.
// - ROM regions: table at 0, test 2000h-205Fh, waveforms from 2060h.
// - Table entry gives start, stop and edit flag; 1,024 per bank.
// - Edit phrases chain stored phrases back to back, no step limit.
// - Edit silences last 20 to 1,024 ms in 4 ms steps.
// - Edit area is only read when a phrase flags edit use.
// - Bank base follows select pins per configured bank count.
// - Ten-bit phrase number per bank; four banks give 4096.
// - Two banks: low pin picks lower half or upper from 100000h.
// - Four banks: pins pick quarters at 0, 80000h, 100000h, 180000h.
// - Bank count 00 one, 01 two, 10 four; 11 acts as 10.
// - Power-up byte, six zero bits plus count, leaves power-down.
// - Power-up accepted only in power-down; host sends it only then.
// - Power-down at power-on, reset pin low, or after power-down command.
// - Power-up leaves amplifier off; only analog mode enables it.
// - Power-up turns the regulator output on.
// - Commands during oscillator settling are discarded.
// - Reset pin low forces power-down at once, even while settling.
// - Ready flag low during command work or address fetch.
module prb_ctrl
    import prb_pkg::*;
#(
    parameter int unsigned OSC_STAB_CYC = OSC_STAB_CYC_DEF,
    parameter int unsigned SIL_STEP_CYC = SIL_STEP_CYC_DEF
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Device pins
    input wire logic reset_low_pin_n_i,
    input wire logic bank_pick_lo_pin_i,
    input wire logic bank_pick_hi_pin_i,
    // Command port (deframed bytes) and status
    input wire prb_cmd_t cmd_i,
    output logic command_ready_flag_o,
    output logic playback_active_flag_n_o,
    output logic command_busy_pin_n_o,
    // Analog controls
    output logic regulator_en_o,
    output logic amp_en_o,
    // Voice ROM read port
    output prb_rom_req_t rom_req_o,
    input wire logic rom_valid_i,
    input wire logic [7:0] rom_data_i,
    // Sample decoder
    output prb_play_t play_o,
    input wire logic play_done_i
);

    localparam logic [CNT_W-1:0] OSC_LAST = CNT_W'(OSC_STAB_CYC - 1);
    localparam logic [CNT_W-1:0] SIL_LAST = CNT_W'(SIL_STEP_CYC - 1);
    localparam logic [CNT_W-1:0] CMD_LAST = CNT_W'(CMD_PROC_CYC - 1);

    // ============================================================
    // State
    typedef struct packed {
        prb_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [1:0] bank_cnt;
        logic [9:0] phrase;
        logic [2:0] idx;
        logic [7:0] flags;
        logic [23:0] start;
        logic [23:0] stop;
        logic in_seq;
        logic [20:0] seq_ptr;
        logic [7:0] item_hi;
        logic [8:0] sil;
        logic pend_play;
        logic [1:0] play_hi;
        logic pend_analog_mode_command;
        logic amp_en;
        logic reg_en;
        prb_rom_req_t rom;
        prb_play_t play;
    } prb_ctrl_st_t;

    prb_ctrl_st_t r, nx;
    logic [20:0] bank_base;

    // Offset within the current bank, wrapped to the ROM width
    function automatic logic [20:0] rom_add(input logic [20:0] base,
                                            input logic [20:0] off);
        logic [21:0] sum;
        sum = {1'b0, base} + {1'b0, off};
        return sum[20:0];
    endfunction

    function automatic logic is_pup(input logic [7:0] b);
        return (b & CMD_PUP_MASK) == CMD_PUP_VAL;
    endfunction

    // ============================================================
    // Bank base
    prb_bank_map u_bank_map (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .bank_cnt_i(r.bank_cnt),
        .bank_pick_lo_pin_i(bank_pick_lo_pin_i),
        .bank_pick_hi_pin_i(bank_pick_hi_pin_i),
        .base_o(bank_base)
    );

    // ============================================================
    // Next state
    always_comb begin
        logic [23:0] stop_full;
        logic [7:0] steps;
        stop_full = {r.stop[15:0], rom_data_i};
        steps = (rom_data_i > SIL_MAX_STEPS) ? SIL_MAX_STEPS : rom_data_i;
        nx = r;
        nx.rom.rd = 1'b0;
        nx.play.start = 1'b0;
        case (r.st)
            S_PDOWN: begin
                if (cmd_i.valid && is_pup(cmd_i.data)) begin
                    nx.st = S_OSC;
                    nx.cnt = '0;
                    nx.bank_cnt = cmd_i.data[1:0];
                    nx.reg_en = 1'b1;
                    nx.amp_en = 1'b0;
                end
            end
            S_OSC: begin
                // Any byte arriving now is dropped on the floor
                if (r.cnt == OSC_LAST) begin
                    nx.st = S_IDLE;
                end else begin
                    nx.cnt = r.cnt + 24'h1;
                end
            end
            S_IDLE: begin
                if (cmd_i.valid) begin
                    nx.cnt = '0;
                    if (r.pend_play) begin
                        nx.pend_play = 1'b0;
                        nx.phrase = {r.play_hi, cmd_i.data};
                        nx.in_seq = 1'b0;
                        nx.idx = ENTRY_FLAGS;
                        nx.st = S_FREQ;
                    end else if (r.pend_analog_mode_command) begin
                        nx.pend_analog_mode_command = 1'b0;
                        nx.amp_en = cmd_i.data[ANALOG_MODE_COMMAND_SPEN_BIT];
                        nx.st = S_CMD;
                    end else if (cmd_i.data == CMD_POWER_DOWN_COMMAND) begin
                        nx.st = S_POWER_DOWN_COMMAND;
                    end else if ((cmd_i.data & CMD_PLAY_MASK)
                                 == CMD_PLAY_VAL) begin
                        nx.pend_play = 1'b1;
                        nx.play_hi = cmd_i.data[PLAY_HI_LSB +: 2];
                        nx.st = S_CMD;
                    end else if (cmd_i.data == CMD_ANALOG_MODE_COMMAND) begin
                        nx.pend_analog_mode_command = 1'b1;
                        nx.st = S_CMD;
                    end else if (!is_pup(cmd_i.data)) begin
                        nx.st = S_CMD;
                    end
                end
            end
            S_CMD: begin
                if (r.cnt == CMD_LAST) begin
                    nx.st = S_IDLE;
                end else begin
                    nx.cnt = r.cnt + 24'h1;
                end
            end
            S_POWER_DOWN_COMMAND: begin
                // Busy pin rises as the device drops into power-down
                if (r.cnt == CMD_LAST) begin
                    nx = '0;
                    nx.st = S_PDOWN;
                end else begin
                    nx.cnt = r.cnt + 24'h1;
                end
            end
            S_FREQ: begin
                nx.rom.rd = 1'b1;
                nx.rom.addr = rom_add(bank_base,
                                      21'({r.phrase, r.idx}));
                nx.st = S_FWAIT;
            end
            S_FWAIT: begin
                if (rom_valid_i) begin
                    if (r.idx == ENTRY_FLAGS) begin
                        nx.flags = rom_data_i;
                    end else if (r.idx <= ENTRY_START_LAST) begin
                        nx.start = {r.start[15:0], rom_data_i};
                    end else begin
                        nx.stop = stop_full;
                    end
                    if (r.idx != ENTRY_LAST) begin
                        nx.idx = r.idx + 3'h1;
                        nx.st = S_FREQ;
                    end else if (r.flags[FLAG_EDIT_BIT] && !r.in_seq) begin
                        // Nested edit flags inside a chain are not followed
                        nx.in_seq = 1'b1;
                        nx.seq_ptr = rom_add(bank_base, r.start[20:0]);
                        nx.idx = 3'h0;
                        nx.st = S_SREQ;
                    end else if (r.start[20:0] < WAVE_BASE
                                 || stop_full < r.start) begin
                        // Entry points at table or test area, or stop lies before start: skip it
                        nx.idx = 3'h0;
                        nx.st = r.in_seq ? S_SREQ : S_IDLE;
                    end else begin
                        nx.play.start = 1'b1;
                        nx.play.format = prb_fmt_t'(r.flags[1:0]);
                        nx.play.start_addr = rom_add(bank_base,
                                                     r.start[20:0]);
                        nx.play.stop_addr = rom_add(bank_base,
                                                    stop_full[20:0]);
                        nx.st = S_PLAY;
                    end
                end
            end
            S_PLAY: begin
                if (play_done_i) begin
                    nx.idx = 3'h0;
                    nx.st = r.in_seq ? S_SREQ : S_IDLE;
                end
            end
            S_SREQ: begin
                nx.rom.rd = 1'b1;
                nx.rom.addr = r.seq_ptr;
                nx.st = S_SWAIT;
            end
            S_SWAIT: begin
                if (rom_valid_i) begin
                    nx.seq_ptr = r.seq_ptr + 21'h1;
                    if (r.idx == 3'h0) begin
                        nx.item_hi = rom_data_i;
                        nx.idx = 3'h1;
                        nx.st = S_SREQ;
                    end else if (r.item_hi[7:6] == ITEM_PHRASE) begin
                        nx.phrase = {r.item_hi[1:0], rom_data_i};
                        nx.idx = ENTRY_FLAGS;
                        nx.st = S_FREQ;
                    end else if (r.item_hi[7:6] == ITEM_SILENCE) begin
                        nx.sil = SIL_BASE_TICKS + 9'(steps);
                        nx.cnt = '0;
                        nx.st = S_SIL;
                    end else begin
                        nx.in_seq = 1'b0;
                        nx.st = S_IDLE;
                    end
                end
            end
            S_SIL: begin
                // One tick per 4 ms step
                if (r.cnt == SIL_LAST) begin
                    nx.cnt = '0;
                    if (r.sil == 9'h001) begin
                        nx.idx = 3'h0;
                        nx.st = S_SREQ;
                    end else begin
                        nx.sil = r.sil - 9'h001;
                    end
                end else begin
                    nx.cnt = r.cnt + 24'h1;
                end
            end
            default: begin
                nx.st = S_PDOWN;
            end
        endcase
        // Reset pin overrides everything, settling included
        if (!reset_low_pin_n_i) begin
            nx = '0;
            nx.st = S_PDOWN;
        end
    end

    // State register
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r <= '0;
        end else begin
            r <= nx;
        end
    end

    // ============================================================
    // Outputs
    assign command_ready_flag_o = !(r.st inside {S_OSC, S_CMD, S_POWER_DOWN_COMMAND,
        S_FREQ, S_FWAIT, S_SREQ, S_SWAIT});
    assign playback_active_flag_n_o = (r.st inside {S_PDOWN, S_IDLE});
    assign command_busy_pin_n_o = !(r.st inside {S_OSC, S_CMD, S_POWER_DOWN_COMMAND});
    assign regulator_en_o = r.reg_en;
    assign amp_en_o = r.amp_en;
    assign rom_req_o = r.rom;
    assign play_o = r.play;

    // ============================================================
    // Checks
    a_pup_enters: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        (r.st == S_PDOWN && cmd_i.valid && is_pup(cmd_i.data)
         && reset_low_pin_n_i) |=> (r.st == S_OSC && regulator_en_o
         && !amp_en_o))
        else $error("power-up byte did not start settling");
    a_pup_refused: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        (r.st == S_IDLE && cmd_i.valid && is_pup(cmd_i.data)
         && !r.pend_play && !r.pend_analog_mode_command && reset_low_pin_n_i)
        |=> r.st == S_IDLE && $stable(r.bank_cnt))
        else $error("power-up accepted outside power-down");
    a_osc_discard: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        (r.st == S_OSC && r.cnt != OSC_LAST && reset_low_pin_n_i)
        |=> r.st == S_OSC && $stable(amp_en_o))
        else $error("command acted on during settling");
    a_reset_pin: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        !reset_low_pin_n_i |=> r.st == S_PDOWN && !regulator_en_o
        && !amp_en_o)
        else $error("reset pin did not force power-down");
    a_ready_settle: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        r.st == S_OSC |-> !command_ready_flag_o)
        else $error("ready high while settling");
    a_ready_fetch: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        rom_req_o.rd |-> !command_ready_flag_o)
        else $error("ready high during address fetch");
    a_power_down_command_seq: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i || !reset_low_pin_n_i)
        (r.st == S_IDLE && cmd_i.valid && cmd_i.data == CMD_POWER_DOWN_COMMAND
         && !r.pend_play && !r.pend_analog_mode_command)
        |=> (!command_busy_pin_n_o)[*4] ##1
        (r.st == S_PDOWN && command_busy_pin_n_o))
        else $error("power-down sequence wrong");
    a_play_region: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        play_o.start |-> r.start[20:0] >= WAVE_BASE)
        else $error("playback started outside voice area");
    a_edit_only: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        r.st == S_SREQ |-> r.in_seq)
        else $error("edit area read without edit phrase");
    a_sil_range: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        $rose(r.st == S_SIL) |-> r.sil >= SIL_BASE_TICKS
        && r.sil <= 9'h100)
        else $error("silence length out of range");

    c_pup: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        r.st == S_OSC ##1 r.st == S_IDLE);
    c_play: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        play_o.start);
    c_silence: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        r.st == S_SIL);
    c_chain_end: cover property (@(posedge ref_clk_i)
        disable iff (sys_rst_i) $fell(r.in_seq) && r.st == S_IDLE);

endmodule // prb_ctrl

// >>> verification/prb_rom_model.sv
`timescale 1ns/1ps
// ============================================================
// Voice ROM and sample decoder stand-in
module prb_rom_model
    import prb_pkg::*;
(
    // Clock
    input wire logic ref_clk_i,
    // Device side
    input wire prb_rom_req_t rom_req_i,
    input wire prb_play_t play_i,
    input wire logic slow_i,
    output logic rom_valid_o,
    output logic [7:0] rom_data_o,
    output logic play_done_o
);
    logic vld_r = 1'b0;
    logic done_r = 1'b0;
    logic [7:0] dat_r = 8'h00;
    logic [2:0] wait_r = 3'h0;
    logic [2:0] play_r = 3'h0;
    logic [20:0] addr_r = 21'h0;
    assign rom_valid_o = vld_r;
    assign rom_data_o = dat_r;
    assign play_done_o = done_r;

    // Entry: no edit, format from phrase, start 4000h, stop 50xxh
    function automatic logic [7:0] entry(input logic [20:0] a);
        case (a[2:0])
            3'h0: entry = {6'h00, a[4:3]};
            3'h2: entry = 8'h40;
            3'h5: entry = 8'h50;
            3'h6: entry = a[10:3];
            default: entry = 8'h00;
        endcase
    endfunction

    // One read outstanding; slow mode stretches the answer
    always_ff @(posedge ref_clk_i) begin
        vld_r <= 1'b0;
        done_r <= 1'b0;
        dat_r <= ~dat_r; // Idle data toggles so a stale byte never passes
        if (rom_req_i.rd) begin
            addr_r <= rom_req_i.addr;
            wait_r <= slow_i ? 3'h4 : 3'h1;
        end else if (wait_r == 3'h1) begin
            wait_r <= 3'h0;
            vld_r <= 1'b1;
            dat_r <= entry(addr_r);
        end else if (wait_r != 3'h0) begin
            wait_r <= wait_r - 3'h1;
        end
        if (play_i.start) begin
            play_r <= 3'h5;
        end else if (play_r != 3'h0) begin
            play_r <= play_r - 3'h1;
            done_r <= (play_r == 3'h1);
        end
    end
endmodule // prb_rom_model

// >>> verification/tb.sv
`timescale 1ns/1ps
// ============================================================
// Bench for the phrase ROM control block
module tb;
    import prb_pkg::*;
    logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, rst_pin_n = 1'b1;
    logic pick_lo = 1'b0, pick_hi = 1'b0, slow = 1'b0;
    logic ready, play_n, reg_en, amp, vld, done, busy_n;
    logic [7:0] rdata;
    prb_cmd_t cmd = '0;
    prb_rom_req_t req;
    prb_play_t play;
    int n_errors = 0, n_checks = 0, cyc = 0;
    logic [31:0] seed = 32'h0417a42e;

    always #5 ref_clk_i = ~ref_clk_i;

    prb_ctrl #(.OSC_STAB_CYC(20), .SIL_STEP_CYC(10)) uut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .reset_low_pin_n_i(rst_pin_n), .bank_pick_lo_pin_i(pick_lo),
        .bank_pick_hi_pin_i(pick_hi), .cmd_i(cmd),
        .command_ready_flag_o(ready), .playback_active_flag_n_o(play_n),
        .command_busy_pin_n_o(busy_n), .regulator_en_o(reg_en),
        .amp_en_o(amp),
        .rom_req_o(req), .rom_valid_i(vld), .rom_data_i(rdata),
        .play_o(play), .play_done_i(done));

    prb_rom_model rom (.ref_clk_i(ref_clk_i), .rom_req_i(req),
        .play_i(play), .slow_i(slow), .rom_valid_o(vld),
        .rom_data_o(rdata), .play_done_o(done));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Bank base from count code and pins; pins unused by the count drop out
    function automatic logic [20:0] exp_base(logic [1:0] c, logic hi, lo);
        if (c == 2'h0) return 21'h0;
        if (c == 2'h1) return lo ? 21'h100000 : 21'h0;
        return {hi, lo, 19'h0};
    endfunction

    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic send(input logic [7:0] b);
        @(posedge ref_clk_i) cmd <= '{valid: 1'b1, data: b};
        @(posedge ref_clk_i) cmd.valid <= 1'b0;
    endtask

    // Flags are read at the edge, so the first look skips the taking edge
    task automatic wait_ready();
        @(posedge ref_clk_i);
        while (ready !== 1'b1) @(posedge ref_clk_i);
    endtask

    task automatic end_of_test();
        if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog against a hung handshake
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            end_of_test();
        end
    end

    initial begin
        logic [1:0] code;
        logic [9:0] ph;
        logic [20:0] base;
        logic [31:0] rnd;
        repeat (4) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(negedge ref_clk_i) chk(21'({ready, reg_en, amp}), 21'h4);
        for (int t = 0; t < 8; t++) begin
            code = t[1:0];
            slow = t[2];
            send({6'h00, code});
            @(negedge ref_clk_i) chk(21'({reg_en, ready, amp}), 21'h4);
            send(CMD_POWER_DOWN_COMMAND);
            wait_ready();
            send({6'h00, code});
            @(negedge ref_clk_i) chk(21'({reg_en, ready}), 21'h3);
            rnd = xs();
            ph = rnd[9:0];
            rnd = xs();
            @(posedge ref_clk_i) {pick_hi, pick_lo} <= rnd[1:0];
            send(CMD_PLAY_VAL | {4'h0, ph[9:8], 2'h0});
            wait_ready();
            send(ph[7:0]);
            base = exp_base(code, pick_hi, pick_lo);
            // Start stands one cycle; look at it mid-cycle where it is settled
            while (play.start !== 1'b1) @(negedge ref_clk_i);
            chk(play.start_addr, base + 21'h004000);
            chk(play.stop_addr, base + 21'h005000 + 21'(ph[7:0]));
            chk(21'(play.format), 21'(ph[1:0]));
            while (play_n !== 1'b1) @(posedge ref_clk_i);
            send(CMD_ANALOG_MODE_COMMAND);
            wait_ready();
            send(8'h02);
            wait_ready();
            @(negedge ref_clk_i) chk(21'(amp), 21'h1);
            send(CMD_POWER_DOWN_COMMAND);
            @(negedge ref_clk_i) chk(21'(busy_n), 21'h0);
            wait_ready();
            @(negedge ref_clk_i) chk(21'({reg_en, amp}), 21'h0);
        end
        send(8'h02);
        repeat (3) @(posedge ref_clk_i);
        rst_pin_n <= 1'b0;
        @(posedge ref_clk_i) rst_pin_n <= 1'b1;
        @(negedge ref_clk_i) chk(21'({reg_en, ready}), 21'h1);
        end_of_test();
    end
endmodule // tb
